// >>> logic/bus_node_consts.svh
/*
 * Constants of the bus node address decode and status block: offsets, field positions, region bounds, timing.
 * Assumes a single 10 MHz bus clock and a 30-bit location field below two transfer-size bits.
 */
// Overview of operation
// RULE_01 - Location bit 29 low selects memory space, high selects I/O space.
// RULE_02 - Top two address bits give transfer size and are not part of the location.
// RULE_03 - Memory references beyond installed memory get no confirmation from this node.
// RULE_04 - Node register space is sixteen 8 KB regions from 2000_0000 to 2001_ffff.
// RULE_05 - Own region starts at base plus slot number times 2000; it holds our registers.
// RULE_06 - Private space at 2002_0000 is served locally and never driven onto the bus.
// RULE_07 - Four 32 MB adapter windows start at 2400_0000, 2600_0000, 2800_0000.
// RULE_08 - The fourth adapter window starts at 2a00_0000, right after the third.
// RULE_09 - Longword references into a window are re-issued on that secondary bus.
// RULE_10 - Secondary address is 2000_0000 plus offset of the reference within its window.
// RULE_11 - Writing one to the halt bit stops the sequencers and idles them.
// RULE_12 - Writing one to the node reset bit clears all internal state.
// RULE_13 - Flag set when a single-bit confirmation code error was corrected.
// RULE_14 - Flag set when recovery from a transient error succeeded.
// RULE_15 - Sequence error flag set when returned read quadwords are missing.
// RULE_16 - Responder-busy timeout flag set when command keeps being refused until timeout.
// RULE_17 - Transaction timeout flag set when a responder never completes in time.
// RULE_18 - Local parity flag set when our receivers see bad parity on a cycle.
// RULE_19 - Flag set when bad parity is reported during our own command cycle.
// RULE_20 - Error flags stay set until written one; type and revision are read-only.
// RULE_21 - Power-low release without reset clears control logic only, memory kept.
// RULE_22 - Power-low release with reset asserted runs full initialization and self-test.
// RULE_23 - Bad parity asserts the fault line, withholds acknowledge and ignores the cycle.
`ifndef BUS_NODE_CONSTS_SVH
`define BUS_NODE_CONSTS_SVH

`define SPACE_IO_BIT      29
`define SIZE_HI_BIT       31
`define SIZE_LO_BIT       30
`define SIZE_LONGWORD     2'h0
`define NODE_SPACE_LO     30'h2000_0000
`define NODE_SPACE_HI     30'h2001_ffff
`define NODE_REGION_SIZE  30'h0000_2000
`define PRIV_SPACE_LO     30'h2002_0000
`define PRIV_SPACE_HI     30'h200f_ffff
`define WIN_SPACE_LO      30'h2400_0000
`define WIN_SPACE_HI      30'h2bff_ffff
`define WIN_SIZE          30'h0200_0000
`define WIN_OFS_MSB       24
`define SEC_ADDR_BASE     30'h2000_0000
`define SLOT_LSB          13
`define SLOT_MSB          16
`define REG_OFS_MSB       12
`define ERR_REG_OFS       13'h0004
`define BIT_HALT          31
`define BIT_NODE_RESET    30
`define BIT_CNF_FIXED     29
`define BIT_RECOVERED     28
`define BIT_SEQ_ERR       27
`define BIT_BUSY_TMO      26
`define BIT_TXN_TMO       25
`define BIT_LOCAL_PAR     24
`define BIT_CMD_PAR       23
`define FLAG_LSB          23
`define FLAG_MSB          29
`define REV_LSB           8
`define REV_MSB           15
`define TYPE_LSB          0
`define TYPE_MSB          7
`define DEV_TYPE_VAL      8'h5a
`define REV_VAL           8'h01
`define CLK_PERIOD_NS     100
`define SELFTEST_NS       2000
`define SELFTEST_CYCLES   ((`SELFTEST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> logic/bus_node_pkg.sv
/*
 * Types of the bus node address decode block: cycle carriers, request carriers, sequence states.
 * Assumes the constants header is compiled alongside.
 */
package bus_node_pkg;

	// One bus cycle as seen at the node receivers
	typedef struct packed {
		logic        valid;
		logic        from_bus;
		logic        write;
		logic [31:0] ad;
		logic [31:0] data;
		logic        parity;
	} bus_cycle_type;

	// Re-issue request to a secondary bus
	typedef struct packed {
		logic        valid;
		logic [1:0]  sel;
		logic        write;
		logic [29:0] addr;
		logic [31:0] data;
	} sec_req_type;

	// Error events reported by the node sequencers
	typedef struct packed {
		logic cnf_fixed;
		logic recovered;
		logic seq_err;
		logic busy_tmo;
		logic txn_tmo;
		logic cmd_par;
	} err_event_type;

	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_LOW  = 3'b010,
		ST_TEST = 3'b100
	} pwr_state_type;

endpackage

// >>> logic/sync_2ff.sv
/*
 * Two-stage synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; multi-bit words must be stable while read.
 */
`timescale 1ns/1ps
module sync_2ff #(
	parameter int W = 1
) (
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;

	// First stage is read only by the second stage
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge mclk_i) begin
				if (sys_rst_i) begin
					meta_reg[g] <= 1'b0;
					sync_o[g]   <= 1'b0;
				end else begin
					meta_reg[g] <= async_i[g];
					sync_o[g]   <= meta_reg[g];
				end
			end
		end
	endgenerate
endmodule

// >>> logic/bus_node_address_decode.sv
/*
 * Address decode, status register and power-low sequence of one bus node.
 * Assumes cycles arrive on mclk_i; slot, power-low and reset lines are pins and are synchronised here.
 */
`timescale 1ns/1ps
`include "bus_node_consts.svh"
module bus_node_address_decode
	import bus_node_pkg::*;
(
	input  wire logic          mclk_i,
	input  wire logic          sys_rst_i,
	input  wire bus_cycle_type cyc_i,
	input  wire logic [29:0]   mem_limit_i,
	input  wire err_event_type err_ev_i,
	input  wire logic [3:0]    slot_number_i,
	input  wire logic          power_low_line_i,
	input  wire logic          reset_line_i,
	output logic               acknowledge_confirm_o,
	output logic               parity_fault_line_o,
	output logic               parity_fault_line_oe_o,
	output logic               bus_issue_o,
	output logic               local_req_o,
	output logic [29:0]        local_addr_o,
	output sec_req_type        sec_req_o,
	output logic [31:0]        rdata_o,
	output logic               rdata_valid_o,
	output logic               halt_o,
	output logic               ctrl_clear_o,
	output logic               selftest_o
);
	// Inclusive range check used for the node, private and window space decodes
	function automatic logic in_range(input logic [29:0] a, input logic [29:0] lo, input logic [29:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Pin inputs through two flip-flops
	logic [3:0] slot_s;
	logic       pwr_low_s;
	logic       rst_line_s;
	sync_2ff #(.W(6)) u_sync (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({slot_number_i, power_low_line_i, reset_line_i}),
		.sync_o    ({slot_s, pwr_low_s, rst_line_s})
	);

	// Decode of the presented cycle
	wire [29:0] loc        = cyc_i.ad[29:0];                                      // [RULE_02]
	wire [1:0]  xfer_size  = cyc_i.ad[`SIZE_HI_BIT:`SIZE_LO_BIT];                 // [RULE_02]
	wire        io_space   = loc[`SPACE_IO_BIT];                                  // [RULE_01]
	wire        mem_hit    = !io_space && (loc < mem_limit_i);                    // [RULE_01] [RULE_03]
	wire        node_hit   = in_range(loc, `NODE_SPACE_LO, `NODE_SPACE_HI);       // [RULE_04]
	wire [29:0] own_base   = `NODE_SPACE_LO + 30'(slot_s) * `NODE_REGION_SIZE;    // [RULE_05]
	wire        own_hit    = node_hit && (loc[29:`SLOT_LSB] == own_base[29:`SLOT_LSB]);
	wire        priv_hit   = in_range(loc, `PRIV_SPACE_LO, `PRIV_SPACE_HI);       // [RULE_06]
	wire        win_hit    = in_range(loc, `WIN_SPACE_LO, `WIN_SPACE_HI);         // [RULE_07] [RULE_08]
	wire [29:0] win_rel    = loc - `WIN_SPACE_LO;
	wire [1:0]  win_idx    = win_rel[`WIN_OFS_MSB+2:`WIN_OFS_MSB+1];              // [RULE_07] [RULE_08]
	wire [29:0] win_ofs    = {5'h00, win_rel[`WIN_OFS_MSB:0]};
	wire [29:0] sec_addr   = `SEC_ADDR_BASE + win_ofs;                            // [RULE_10]
	wire        reg_hit    = own_hit && (loc[`REG_OFS_MSB:0] == `ERR_REG_OFS);
	wire        bad_par    = cyc_i.valid && cyc_i.from_bus && ((^{cyc_i.ad, cyc_i.data}) != cyc_i.parity);

	// State and flags
	pwr_state_type state_reg, state_next;
	logic [6:0]    flags_reg, flags_next;
	logic          halt_reg;
	logic [15:0]   test_cnt_reg;
	logic          pwr_low_d_reg;
	logic          nreset_pulse_reg;

	wire up_ok     = (state_reg == ST_RUN) && !nreset_pulse_reg;
	wire good_bus  = cyc_i.valid && cyc_i.from_bus && !bad_par && up_ok;         // [RULE_23]
	wire good_loc  = cyc_i.valid && !cyc_i.from_bus && up_ok;
	wire reg_wr    = good_bus && reg_hit && cyc_i.write;
	wire reg_rd    = good_bus && reg_hit && !cyc_i.write;
	wire win_go    = good_bus && win_hit && io_space && (xfer_size == `SIZE_LONGWORD) && !halt_reg; // [RULE_09]
	wire pwr_fall  = pwr_low_d_reg && !pwr_low_s;
	wire soft_rst  = nreset_pulse_reg;                                            // [RULE_12]

	// Event vector in flag order, high bit first
	wire [6:0] ev_vec = {err_ev_i.cnf_fixed, err_ev_i.recovered, err_ev_i.seq_err,  // [RULE_13] [RULE_14] [RULE_15]
	                     err_ev_i.busy_tmo, err_ev_i.txn_tmo, bad_par,            // [RULE_16] [RULE_17] [RULE_18]
	                     err_ev_i.cmd_par};                                       // [RULE_19]
	wire [6:0] w1c_vec = reg_wr ? cyc_i.data[`FLAG_MSB:`FLAG_LSB] : 7'h00;

	// Set wins over the write-one clear so a coincident event is kept
	assign flags_next = (flags_reg & ~w1c_vec) | ev_vec;                          // [RULE_20]

	wire [31:0] err_reg_view = {halt_reg, 1'b0, flags_reg, 7'h00,
	                            `REV_VAL, `DEV_TYPE_VAL};                         // [RULE_20]

	// Power-low sequence
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN:  if (pwr_low_s) state_next = ST_LOW;
			ST_LOW:  if (pwr_fall) state_next = rst_line_s ? ST_TEST : ST_RUN;   // [RULE_21] [RULE_22]
			ST_TEST: if (test_cnt_reg == 16'(`SELFTEST_CYCLES - 1)) state_next = ST_RUN;
			default: state_next = ST_RUN;
		endcase
	end

	// Sequence state, self-test counter and line history
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_reg     <= ST_RUN;
			test_cnt_reg  <= 16'h0000;
			pwr_low_d_reg <= 1'b0;
		end else begin
			state_reg     <= soft_rst ? ST_RUN : state_next;
			test_cnt_reg  <= (state_reg == ST_TEST) ? test_cnt_reg + 16'h0001 : 16'h0000;
			pwr_low_d_reg <= pwr_low_s;
		end
	end

	// Status flags, halt and node reset; soft reset and power-low release clear them
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			flags_reg        <= 7'h00;
			halt_reg         <= 1'b0;
			nreset_pulse_reg <= 1'b0;
		end else if (soft_rst || (state_reg == ST_LOW && pwr_fall)) begin
			flags_reg        <= 7'h00;                                            // [RULE_12] [RULE_21]
			halt_reg         <= 1'b0;
			nreset_pulse_reg <= 1'b0;
		end else begin
			flags_reg        <= flags_next;
			if (reg_wr) halt_reg <= cyc_i.data[`BIT_HALT];                       // [RULE_11]
			nreset_pulse_reg <= reg_wr && cyc_i.data[`BIT_NODE_RESET];            // [RULE_12]
		end
	end

	// Bus facing answers: confirmation, parity fault and register read
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			acknowledge_confirm_o  <= 1'b0;
			parity_fault_line_o    <= 1'b0;
			parity_fault_line_oe_o <= 1'b0;
			rdata_o                <= 32'h0000_0000;
			rdata_valid_o          <= 1'b0;
		end else begin
			acknowledge_confirm_o  <= good_bus && (mem_hit || own_hit || win_go); // [RULE_03] [RULE_23]
			parity_fault_line_o    <= bad_par;                                    // [RULE_23]
			parity_fault_line_oe_o <= bad_par;
			rdata_o                <= reg_rd ? err_reg_view : 32'h0000_0000;
			rdata_valid_o          <= reg_rd;
		end
	end

	// Commander side routing and adapter re-issue; halt idles the issue paths
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			bus_issue_o  <= 1'b0;
			local_req_o  <= 1'b0;
			local_addr_o <= 30'h0000_0000;
			sec_req_o    <= '0;
		end else begin
			local_req_o     <= good_loc && priv_hit;                              // [RULE_06]
			local_addr_o    <= loc;
			bus_issue_o     <= good_loc && !priv_hit && !halt_reg;                // [RULE_06] [RULE_11]
			sec_req_o.valid <= win_go;                                            // [RULE_09]
			sec_req_o.sel   <= win_idx;
			sec_req_o.write <= cyc_i.write;                                       // [RULE_09]
			sec_req_o.addr  <= sec_addr;                                          // [RULE_10]
			sec_req_o.data  <= cyc_i.data;
		end
	end

	// Status lines toward the rest of the node
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			halt_o       <= 1'b0;
			ctrl_clear_o <= 1'b0;
			selftest_o   <= 1'b0;
		end else begin
			halt_o       <= halt_reg;                                             // [RULE_11]
			ctrl_clear_o <= (state_reg == ST_LOW && pwr_fall && !rst_line_s) || soft_rst; // [RULE_21]
			selftest_o   <= (state_next == ST_TEST);                              // [RULE_22]
		end
	end

	// Checks next to the logic
	chk_mem_no_ack: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_03]
		(cyc_i.valid && cyc_i.from_bus && !cyc_i.ad[29] && cyc_i.ad[29:0] >= mem_limit_i
		 && !own_hit && !win_go) |=> !acknowledge_confirm_o)
		else $error("absent memory confirmed");
	chk_par_nack: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_23]
		bad_par |=> (parity_fault_line_oe_o && parity_fault_line_o && !acknowledge_confirm_o && !rdata_valid_o))
		else $error("bad parity not handled");
	chk_priv_local: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_06]
		(good_loc && priv_hit) |=> (local_req_o && !bus_issue_o))
		else $error("private reference left the node");
	chk_win_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_10]
		win_go |=> (sec_req_o.addr == `SEC_ADDR_BASE + (($past(loc) - `WIN_SPACE_LO) % `WIN_SIZE)))
		else $error("secondary address wrong");
	chk_win_sel: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_08]
		(win_go && loc >= 30'h2a00_0000) |=> (sec_req_o.valid && sec_req_o.sel == 2'h3))
		else $error("fourth window not selected");
	chk_win_size: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_09]
		sec_req_o.valid |-> $past(xfer_size == `SIZE_LONGWORD && !halt_reg))
		else $error("non-longword or halted re-issue");
	chk_flag_sticky: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_20]
		(flags_reg[1] && !w1c_vec[1] && !soft_rst && !(state_reg == ST_LOW && pwr_fall)) |=> flags_reg[1])
		else $error("flag dropped without clear");
	chk_flag_set: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_18]
		(bad_par && !soft_rst && !(state_reg == ST_LOW && pwr_fall)) |=> flags_reg[1])
		else $error("local parity flag not set");
	chk_halt_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_11]
		halt_reg |=> !bus_issue_o && !sec_req_o.valid)
		else $error("issue while halted");
	chk_test_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_22]
		(state_reg == ST_LOW && pwr_fall && rst_line_s && !soft_rst) |=> (state_reg == ST_TEST) [*8])
		else $error("self-test too short");
	chk_warm_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_21]
		(state_reg == ST_LOW && pwr_fall && !rst_line_s) |=> (ctrl_clear_o && state_reg == ST_RUN && flags_reg == 7'h00))
		else $error("warm clear missing");
	chk_node_reset: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_12]
		(reg_wr && cyc_i.data[`BIT_NODE_RESET] && state_reg == ST_RUN) |=> ##1 (flags_reg == 7'h00 && !halt_reg))
		else $error("node reset did not clear");
endmodule

// >>> sim/bus_peer_model.sv
/*
 * Far-side bus node: drives one bus cycle per call of send, releases the lines with idle.
 * Assumes the caller sits just after a rising edge of mclk_i.
 */
`timescale 1ns/1ps
module bus_peer_model
	import bus_node_pkg::*;
(
	input  wire logic    mclk_i,
	output bus_cycle_type cyc_o
);
	initial cyc_o = '0;

	// One cycle; bad asks for a parity error on purpose
	task automatic send(input logic fb, input logic wr, input logic [31:0] ad, input logic [31:0] dat, input logic bad);
		cyc_o <= {1'b1, fb, wr, ad, dat, (^{ad, dat}) ^ bad};
		@(posedge mclk_i);
	endtask

	// Released lines show the inverse of the last word, so no stale copy can pass as valid
	task automatic idle(input int n);
		repeat (n) begin
			cyc_o <= {3'h0, ~cyc_o.ad, ~cyc_o.data, 1'b0};
			@(posedge mclk_i);
		end
	endtask
endmodule

// >>> sim/bus_node_address_decode_tb_top.sv
/*
 * Testbench of the bus node address decode block: notes of expected answers, a watcher that checks them.
 * Assumes the peer model drives the cycles and the design answers exactly one cycle after taking one.
 */
`timescale 1ns/1ps
`include "bus_node_consts.svh"
module bus_node_address_decode_tb_top
	import bus_node_pkg::*;
;
	typedef struct packed {logic [5:0] f; logic [31:0] v;} note_type;
	logic          mclk_i = 1'b0;
	logic          sys_rst_i, power_low_line_i, reset_line_i;
	logic [3:0]    slot_number_i;
	logic [29:0]   mem_limit_i;
	err_event_type err_ev_i;
	bus_cycle_type cyc_i;
	sec_req_type   sec_req_o;
	logic          ack_o, fault_o, fault_oe_o, bus_issue_o, local_req_o, rdata_valid_o;
	logic          halt_o, ctrl_clear_o, selftest_o, seen, halt_m;
	logic [29:0]   local_addr_o, own, a, off;
	logic [31:0]   rdata_o, r, obs_v;
	logic [5:0]    obs_f;
	logic [6:0]    flags_m;
	note_type      notes[$];
	note_type      n;
	int            mismatches = 0, comparisons = 0, cnt;

	always #50 mclk_i = ~mclk_i;

	bus_peer_model peer_u (.mclk_i(mclk_i), .cyc_o(cyc_i));

	bus_node_address_decode dut_u (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cyc_i(cyc_i), .mem_limit_i(mem_limit_i),
		.err_ev_i(err_ev_i), .slot_number_i(slot_number_i), .power_low_line_i(power_low_line_i),
		.reset_line_i(reset_line_i), .acknowledge_confirm_o(ack_o), .parity_fault_line_o(fault_o),
		.parity_fault_line_oe_o(fault_oe_o), .bus_issue_o(bus_issue_o), .local_req_o(local_req_o),
		.local_addr_o(local_addr_o), .sec_req_o(sec_req_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
		.halt_o(halt_o), .ctrl_clear_o(ctrl_clear_o), .selftest_o(selftest_o)
	);

	task automatic check_val(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic check_flags(input logic [5:0] e, input logic [5:0] g);
		check_val({26'h0, e}, {26'h0, g});
	endtask

	task automatic test_done;
		if (notes.size() != 0)
			mismatches++;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Answer flags: ack, fault, bus issue, local, secondary, read data
	task automatic expect_ans(input logic [5:0] f, input logic [31:0] v);
		notes.push_back({f, v});
	endtask

	task automatic reg_wr(input logic [31:0] d);
		expect_ans(6'b100000, 32'h0);
		peer_u.send(1'b1, 1'b1, {2'h0, own}, d, 1'b0);
		peer_u.idle(1);
	endtask

	task automatic reg_rd;
		expect_ans(6'b100001, {halt_m, 1'b0, flags_m, 7'h0, `REV_VAL, `DEV_TYPE_VAL});
		peer_u.send(1'b1, 1'b0, {2'h0, own}, 32'h0, 1'b0);
		peer_u.idle(1);
	endtask

	// Watcher: every pulse of an answer takes the oldest note; a pulse with no note is a fault
	always @(negedge mclk_i) begin
		obs_f = {ack_o, fault_o & fault_oe_o, bus_issue_o, local_req_o, sec_req_o.valid, rdata_valid_o};
		obs_v = rdata_valid_o ? rdata_o : sec_req_o.valid ? {sec_req_o.sel, sec_req_o.addr} :
			local_req_o ? {2'h0, local_addr_o} : 32'h0;
		if (|obs_f) begin
			if (notes.size() == 0)
				check_flags(6'h0, obs_f);
			else begin
				n = notes.pop_front();
				check_flags(n.f, obs_f);
				check_val(n.v, obs_v);
				if (sec_req_o.valid) begin
					check_val(r, sec_req_o.data);
					check_val(32'h1, {31'h0, sec_req_o.write});
				end
			end
		end
	end

	// Hang guard: counts as a mismatch
	initial begin
		#2_000_000;
		mismatches++;
		test_done();
	end

	// Main sequence
	initial begin
		void'($urandom(60818));
		sys_rst_i        <= 1'b1;
		power_low_line_i <= 1'b0;
		reset_line_i     <= 1'b0;
		err_ev_i         <= '0;
		r = $urandom;
		slot_number_i    <= r[3:0];
		// Installed memory top is random so the limit compare is exercised at varied points
		mem_limit_i      <= 30'h0010_0000 + 30'($urandom_range(0, 32'h0fff_ffff));
		own = 30'h2000_0000 + {13'h0, r[3:0], 13'h0} + 30'h4;
		halt_m = 1'b0;
		flags_m = 7'h0;
		repeat (2) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		r = $urandom;
		expect_ans(6'b100000, 32'h0);
		peer_u.send(1'b1, r[0], {r[31:30], 30'($urandom_range(0, {2'h0, mem_limit_i} - 32'h1))}, r, 1'b0);
		peer_u.send(1'b1, 1'b0, {2'h0, mem_limit_i}, r, 1'b0);
		expect_ans(6'b001000, 32'h0);
		peer_u.send(1'b0, 1'b0, 32'h0000_1000, r, 1'b0);
		a = 30'h2002_0000 + 30'($urandom_range(0, 32'h000d_ffff));
		expect_ans(6'b000100, {2'h0, a});
		peer_u.send(1'b0, 1'b0, {2'h0, a}, r, 1'b0);
		peer_u.send(1'b1, 1'b0, {2'h0, own ^ 30'h2000}, r, 1'b0);
		for (int w = 0; w < 4; w++) begin
			off = 30'($urandom_range(0, 32'h01ff_ffff));
			expect_ans(6'b100010, {2'(w), 30'h2000_0000 + off});
			peer_u.send(1'b1, 1'b1, {2'h0, 30'h2400_0000 + 30'(w) * 30'h0200_0000 + off}, r, 1'b0);
		end
		// Non-longword size into a window: no confirmation and no re-issue
		peer_u.send(1'b1, 1'b1, {2'h1, 30'h2400_0000 + off}, r, 1'b0);
		expect_ans(6'b010000, 32'h0);
		peer_u.send(1'b1, 1'b1, {2'h0, own}, 32'h8000_0000, 1'b1);
		peer_u.idle(1);
		flags_m[1] = 1'b1;
		reg_rd();
		for (int j = 0; j < 6; j++) begin
			err_ev_i <= 6'(1 << j);
			@(posedge mclk_i);
			err_ev_i <= '0;
			@(posedge mclk_i);
			flags_m[(j == 0) ? 0 : j + 1] = 1'b1;
			reg_rd();
		end
		reg_wr(32'h3f80_00ff);
		flags_m = 7'h0;
		reg_rd();
		reg_wr(32'h8000_0000);
		halt_m = 1'b1;
		@(negedge mclk_i);
		check_val(32'h1, {31'h0, halt_o});
		@(posedge mclk_i);
		reg_rd();
		// Halted: neither a shared-bus issue nor a window re-issue may leave
		peer_u.send(1'b0, 1'b0, 32'h0000_1000, r, 1'b0);
		peer_u.send(1'b1, 1'b1, {2'h0, 30'h2400_0000}, r, 1'b0);
		peer_u.idle(1);
		// Node reset: the cycle right behind the write is dropped
		err_ev_i <= 6'h01;
		@(posedge mclk_i);
		err_ev_i <= '0;
		expect_ans(6'b100000, 32'h0);
		peer_u.send(1'b1, 1'b1, {2'h0, own}, 32'hc000_0000, 1'b0);
		peer_u.send(1'b1, 1'b0, 32'h0000_0040, r, 1'b0);
		peer_u.idle(2);
		halt_m = 1'b0;
		check_val(32'h0, {31'h0, halt_o});
		reg_rd();
		// Power low without reset line: control cleared only
		reg_wr(32'h8000_0000);
		halt_m = 1'b1;
		power_low_line_i <= 1'b1;
		peer_u.idle(4);
		peer_u.send(1'b1, 1'b0, 32'h0000_0080, r, 1'b0);
		peer_u.idle(2);
		power_low_line_i <= 1'b0;
		seen = 1'b0;
		for (int i = 0; i < 10; i++) begin
			@(negedge mclk_i);
			if (ctrl_clear_o === 1'b1)
				seen = 1'b1;
		end
		@(posedge mclk_i);
		halt_m = 1'b0;
		check_val(32'h1, {31'h0, seen});
		check_val(32'h0, {31'h0, halt_o});
		reg_rd();
		// Power low released with the reset line high: self-test length
		reset_line_i <= 1'b1;
		power_low_line_i <= 1'b1;
		peer_u.idle(4);
		power_low_line_i <= 1'b0;
		cnt = 0;
		for (int i = 0; i < 60; i++) begin
			@(negedge mclk_i);
			if (selftest_o === 1'b1)
				cnt++;
		end
		@(posedge mclk_i);
		reset_line_i <= 1'b0;
		check_val(32'd20, 32'(cnt));
		peer_u.idle(4);
		reg_rd();
		peer_u.idle(3);
		test_done();
	end
endmodule
